// ==== rpr_array.sv ====
// Word array of the read path.
// Assumes contents are loaded through the program port before reading.
module rpr_array #(
  parameter int unsigned WORDS = rpr_pkg::RPR_WORDS
) (
  input wire logic clk_sys_in,
  input wire logic prog_we_in,
  input wire logic [10:0] prog_addr_in,
  input wire logic [7:0] prog_data_in,
  rpr_fetch_if.array fetch
);
  // ----------------------------------------
  // Storage and fetch
  // ----------------------------------------
  logic [7:0] mem [WORDS]; // RULE_01

  always_ff @(posedge clk_sys_in) begin
    if (prog_we_in) begin
      mem[prog_addr_in] <= prog_data_in;
    end
  end

  assign fetch.word = mem[fetch.addr]; // RULE_03
endmodule

// ==== rpr_fetch_if.sv ====
// Interface between the read path and its array.
// Assumes both ends sit on the system clock.
interface rpr_fetch_if;
  logic [10:0] addr;
  logic [7:0] word;
  modport reader (output addr, input word);
  modport array (input addr, output word);
endinterface

// ==== rpr_host.sv ====
// Host model: raises the register clock for two cycles per request.
// Assumes requests come at least four cycles apart.
module rpr_host (
  input wire logic clk_sys_in,
  input wire logic fire_in,
  output logic register_clock_out
);
  logic [1:0] hold_q = 2'h0;
  always_ff @(posedge clk_sys_in) begin
    if (fire_in) hold_q <= 2'h2;
    else if (hold_q != 2'h0) hold_q <= hold_q - 2'h1;
  end
  assign register_clock_out = hold_q != 2'h0;
endmodule

// ==== rpr_pkg.sv ====
// Constants and types of the registered PROM read path.
// Assumes one system clock; the register clock arrives as a pin and is sampled.
// How it works
// [RULE_01] Array of 2048 eight-bit words, address selected
// [RULE_02] Host holds address, enable low to read
// [RULE_03] Addressed word fetched into master stage
// [RULE_04] Rising register clock moves word to outputs
// [RULE_05] Enable mode chosen once: sync or async
// [RULE_06] Sync mode powers up with outputs off
// [RULE_07] Async mode powers up off if enable high
// [RULE_08] Async enable high turns outputs off at once
// [RULE_09] Initialize loads register without clock edge
// [RULE_10] Initialize loads extra word beyond array
// [RULE_11] Initialize word programmable to any value
// [RULE_12] Sync enable acts at next rising clock
// [RULE_13] Async enable low drives outputs again
// [RULE_14] Outputs steady between clock edges
// [RULE_15] Unprogrammed initialize word is all zeros
// [RULE_16] Initialize beats a coinciding clock edge
package rpr_pkg;
  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int unsigned RPR_WORDS = 2048;
  localparam int unsigned RPR_ADDR_W = 11;
  localparam int unsigned RPR_DATA_W = 8;
  localparam logic [7:0] RPR_INIT_WORD_RST = 8'h00;
  localparam logic [7:0] RPR_DATA_RST = 8'h00;
  localparam logic RPR_SYNC_MODE_RST = 1'b0;
  localparam logic [1:0] RPR_SYNC_RST = 2'h0;
  localparam logic [1:0] RPR_PIN_IDLE_HI = 2'h3;
  localparam logic [10:0] RPR_ADDR_RST = 11'h000;
  localparam logic RPR_CLK_PREV_RST = 1'b0;
  localparam logic RPR_SYNC_OFF_RST = 1'b1;
  localparam logic [7:0] RPR_OE_RST = 8'h00;
  localparam int unsigned RPR_MODE_SETTLE = 2;

  typedef enum logic {
    RPR_EN_ASYNC,
    RPR_EN_SYNC
  } rpr_en_mode_t;
endpackage

// ==== rpr_read_path.sv ====
// Top of the registered PROM read path.
// Assumes pins are asynchronous to clk_sys_in; the register clock, word select, enable, initialize and mode pins are synchronised here.
module rpr_read_path (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic register_clock_in,
  input wire logic [10:0] word_select_in,
  input wire logic enable_n_in,
  input wire logic init_n_in,
  input wire logic sync_mode_in,
  input wire logic prog_we_in,
  input wire logic [10:0] prog_addr_in,
  input wire logic [7:0] prog_data_in,
  input wire logic init_word_we_in,
  input wire logic [7:0] data_out_in,
  output logic [7:0] data_out_out,
  output logic [7:0] data_out_oe_out
);
  // ----------------------------------------
  // Register clock synchroniser
  // ----------------------------------------
  logic [1:0] clk_sync_q;
  logic clk_prev_q;
  logic clk_rise;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      clk_sync_q <= rpr_pkg::RPR_SYNC_RST;
    end else begin
      clk_sync_q <= {clk_sync_q[0], register_clock_in};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      clk_prev_q <= rpr_pkg::RPR_CLK_PREV_RST;
    end else begin
      clk_prev_q <= clk_sync_q[1];
    end
  end

  assign clk_rise = clk_sync_q[1] & ~clk_prev_q;

  // ----------------------------------------
  // Enable synchroniser
  // ----------------------------------------
  logic [1:0] en_sync_q;
  logic en_off;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      en_sync_q <= rpr_pkg::RPR_PIN_IDLE_HI;
    end else begin
      en_sync_q <= {en_sync_q[0], enable_n_in};
    end
  end

  assign en_off = en_sync_q[1];

  // ----------------------------------------
  // Initialize synchroniser
  // ----------------------------------------
  logic [1:0] init_sync_q;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      init_sync_q <= rpr_pkg::RPR_PIN_IDLE_HI;
    end else begin
      init_sync_q <= {init_sync_q[0], init_n_in};
    end
  end

  // ----------------------------------------
  // Address synchroniser
  // ----------------------------------------
  logic [10:0] addr_s1_q;
  logic [10:0] addr_s2_q;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      addr_s1_q <= rpr_pkg::RPR_ADDR_RST;
    end else begin
      addr_s1_q <= word_select_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      addr_s2_q <= rpr_pkg::RPR_ADDR_RST;
    end else begin
      addr_s2_q <= addr_s1_q;
    end
  end

  // ----------------------------------------
  // Mode and initialize word
  // ----------------------------------------
  localparam logic [1:0] SETTLE_CNT = 2'(rpr_pkg::RPR_MODE_SETTLE);
  rpr_pkg::rpr_en_mode_t mode_q;
  logic [1:0] mode_sync_q;
  logic [1:0] settle_q;
  logic mode_taken_q;
  logic [7:0] init_word_q;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      mode_sync_q <= {2{rpr_pkg::RPR_SYNC_MODE_RST}};
    end else begin
      mode_sync_q <= {mode_sync_q[0], sync_mode_in};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      settle_q <= 2'h0;
    end else if (settle_q != SETTLE_CNT) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      mode_q <= rpr_pkg::RPR_EN_ASYNC;
    end else if (!mode_taken_q && settle_q == SETTLE_CNT) begin
      mode_q <= mode_sync_q[1] ? rpr_pkg::RPR_EN_SYNC : rpr_pkg::RPR_EN_ASYNC; // RULE_05
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      mode_taken_q <= 1'b0;
    end else if (settle_q == SETTLE_CNT) begin
      mode_taken_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      init_word_q <= rpr_pkg::RPR_INIT_WORD_RST; // RULE_15
    end else if (init_word_we_in) begin
      init_word_q <= data_out_in; // RULE_11
    end
  end

  // ----------------------------------------
  // Array and master stage
  // ----------------------------------------
  rpr_fetch_if fetch ();
  logic [7:0] master_q;

  assign fetch.addr = addr_s2_q;

  rpr_array u_array (
    .clk_sys_in(clk_sys_in),
    .prog_we_in(prog_we_in),
    .prog_addr_in(prog_addr_in),
    .prog_data_in(prog_data_in),
    .fetch(fetch)
  );

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      master_q <= rpr_pkg::RPR_DATA_RST;
    end else if (!init_sync_q[1]) begin
      master_q <= init_word_q; // RULE_10
    end else begin
      master_q <= fetch.word; // RULE_03
    end
  end

  // ----------------------------------------
  // Slave stage and enables
  // ----------------------------------------
  logic sync_off_q;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      data_out_out <= rpr_pkg::RPR_DATA_RST;
    end else if (!init_sync_q[1]) begin
      data_out_out <= init_word_q; // RULE_09 RULE_16
    end else if (clk_rise) begin
      data_out_out <= master_q; // RULE_04 RULE_14
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      sync_off_q <= rpr_pkg::RPR_SYNC_OFF_RST; // RULE_06
    end else if (clk_rise) begin
      sync_off_q <= en_sync_q[1]; // RULE_12
    end
  end

  // ----------------------------------------
  // Output enable decode
  // ----------------------------------------
  function automatic logic drive_on(
    input logic taken,
    input rpr_pkg::rpr_en_mode_t mode,
    input logic sync_off,
    input logic async_off
  );
    logic on;
    on = 1'b0;
    if (!taken) begin
      on = 1'b0;
    end else if (mode == rpr_pkg::RPR_EN_SYNC) begin
      on = ~sync_off;
    end else begin
      on = ~async_off;
    end
    return on;
  endfunction

  logic drive_d;

  assign drive_d = drive_on(mode_taken_q, mode_q, sync_off_q, en_off);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      data_out_oe_out <= rpr_pkg::RPR_OE_RST;
    end else begin
      data_out_oe_out <= {8{drive_d}}; // RULE_07 RULE_08 RULE_13
    end
  end
endmodule

// ==== rpr_read_path_chk.sv ====
// Port checker of the read path.
// Assumes sync_mode_in changes only in reset.
module rpr_read_path_chk (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic register_clock_in,
  input wire logic enable_n_in,
  input wire logic init_n_in,
  input wire logic sync_mode_in,
  input wire logic init_word_we_in,
  input wire logic [7:0] data_out_in,
  input wire logic [7:0] data_out_out,
  input wire logic [7:0] data_out_oe_out
);
  logic [7:0] iw_q;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence rise_s; $rose(register_clock_in); endsequence
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) iw_q <= 8'h00;
    else if (init_word_we_in) iw_q <= data_out_in;
  end
  a_out_steady: assert property ((init_n_in && !$rose(register_clock_in))[*4] |=>
    $stable(data_out_out)) else $error("data moved without cause");
  a_oe_uniform: assert property (data_out_oe_out inside {8'h00, 8'hff})
    else $error("enable bits differ");
  a_async_off: assert property ((!sync_mode_in && enable_n_in)[*5] |->
    data_out_oe_out == 8'h00) else $error("async off missed");
  a_async_on: assert property ((!sync_mode_in && !enable_n_in)[*5] |->
    data_out_oe_out == 8'hff) else $error("async on missed");
  a_sync_hold: assert property ((sync_mode_in && !$rose(register_clock_in))[*5] |=>
    $stable(data_out_oe_out)) else $error("sync enable moved");
  a_sync_off: assert property ((sync_mode_in && enable_n_in)[*4] ##0 rise_s |->
    ##[3:5] data_out_oe_out == 8'h00) else $error("sync off missed");
  a_sync_on: assert property ((sync_mode_in && !enable_n_in)[*4] ##0 rise_s |->
    ##[3:5] data_out_oe_out == 8'hff) else $error("sync on missed");
  a_sync_power: assert property (sync_mode_in && $rose(rstn_in) |->
    (data_out_oe_out == 8'h00)[*4]) else $error("sync power up driven");
  a_init_load: assert property ((!init_n_in)[*4] |-> data_out_out == iw_q)
    else $error("init word not loaded");
endmodule
bind rpr_read_path rpr_read_path_chk u_chk (.*);

// ==== rpr_read_path_tb_top.sv ====
// Testbench of the registered read path.
// Assumes the host model makes the register clock.
module rpr_read_path_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0, rstn_in = 1'b0, rclk, fire = 1'b0, en_n = 1'b1;
  logic init_n = 1'b1, smode = 1'b0, pwe = 1'b0, iwe = 1'b0;
  logic [10:0] addr = 11'h000;
  logic [7:0] pd = 8'h00, dout, oe;
  int errors = 0, n_compared = 0, cyc = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  rpr_host host (.clk_sys_in(clk_sys_in), .fire_in(fire), .register_clock_out(rclk));
  rpr_read_path dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .register_clock_in(rclk),
    .word_select_in(addr), .enable_n_in(en_n), .init_n_in(init_n), .sync_mode_in(smode),
    .prog_we_in(pwe), .prog_addr_in(addr), .prog_data_in(pd), .init_word_we_in(iwe),
    .data_out_in(pd), .data_out_out(dout), .data_out_oe_out(oe));
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic rst(input logic m, input logic e);
    rstn_in <= 1'b0;
    smode <= m;
    en_n <= e;
    cyc_n(5);
    rstn_in <= 1'b1;
    cyc_n(1);
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic w);
    addr <= a;
    pd <= d;
    if (w) iwe <= 1'b1;
    else pwe <= 1'b1;
    cyc_n(1);
    pwe <= 1'b0;
    iwe <= 1'b0;
    cyc_n(1);
  endtask
  task automatic rd(input logic [10:0] a);
    addr <= a;
    cyc_n(4);
    fire <= 1'b1;
    cyc_n(1);
    fire <= 1'b0;
    cyc_n(8);
  endtask
  task automatic t_async;
    rst(1'b0, 1'b1);
    cyc_n(4);
    chk(oe, 8'h00);
    wr(11'h000, 8'h5a, 1'b0);
    wr(11'h7ff, 8'ha5, 1'b0);
    en_n <= 1'b0;
    rd(11'h000);
    chk(dout, 8'h5a);
    rd(11'h7ff);
    chk(dout, 8'ha5);
    en_n <= 1'b1;
    cyc_n(5);
    chk(oe, 8'h00);
    en_n <= 1'b0;
    cyc_n(5);
    chk(oe, 8'hff);
  endtask
  task automatic t_init;
    init_n <= 1'b0;
    cyc_n(4);
    chk(dout, 8'h00);
    init_n <= 1'b1;
    wr(11'h000, 8'hff, 1'b1);
    init_n <= 1'b0;
    rd(11'h000);
    chk(dout, 8'hff);
    init_n <= 1'b1;
    cyc_n(4);
    chk(dout, 8'hff);
    rd(11'h7ff);
    chk(dout, 8'ha5);
  endtask
  task automatic t_sync;
    rst(1'b1, 1'b0);
    cyc_n(6);
    chk(oe, 8'h00);
    rd(11'h7ff);
    chk(oe, 8'hff);
    en_n <= 1'b1;
    cyc_n(6);
    chk(oe, 8'hff);
    rd(11'h000);
    chk(oe, 8'h00);
  endtask
  initial begin
    t_async;
    t_init;
    t_sync;
    report_and_stop;
  end
endmodule
